// ---- design/supervisor_watchdog_timer.sv ----
// Processor-activity watchdog of the voltage supervisor
`timescale 1ns/10ps
module supervisor_watchdog_timer (
  input wire logic mclk, // 20 MHz device clock
  input wire logic rst_b, // Power-on/boot reset
  input wire logic general_pin_four, // Raw pin level
  input wire logic pin_four_is_kick, // Pin set to kick function
  input wire logic monitor_enable_in, // Raw enable pin level
  input wire logic manual_restart_input_b, // Raw manual restart pin, low active
  input wire logic boot_done, // Boot phase finished
  input wire logic soft_reboot, // Software reboot pulse
  input wire logic other_reset_active, // Supervisor reset from other causes
  input wire logic [3:0] restart_pulse_code, // Restart pulse period code
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  output logic [7:0] reg_rdata, // Register read data
  output logic watchdog_expiry_output_b, // Expiry, low active
  output logic watchdog_reset_out, // Watchdog request on supervisor reset
  output logic watchdog_caused_restart_flag // Restart cause flag
);

  logic [2:0] kick_sync_ff;
  logic [1:0] en_sync_ff;
  logic [1:0] mr_sync_ff;
  logic [7:0] mode_ff;
  wdt_pkg::timing_cfg_t timing_ff;
  logic soft_kick_ff;
  logic flag_ff;
  logic [7:0] rdata_ff;
  logic [4:0] us_div_ff;
  logic us_tick;
  logic [9:0] ms_div_ff;
  logic ms_tick;
  wdt_pkg::wdt_state_t state_ff;
  wdt_pkg::wdt_state_t nxt_state;
  logic [18:0] cnt_ff;
  logic [18:0] nxt_cnt;
  logic wdo_b_ff;
  logic wd_rst_ff;
  logic [19:0] rst_us_ff;
  logic [4:0] pulse_ff;
  logic independent;
  logic kick_edge;
  logic kick;
  logic held;
  logic expire;
  logic rst_start;
  logic ctrl_wr;
  logic status_wr;

  // Pin synchronisers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kick_sync_ff <= 3'h0;
      en_sync_ff <= 2'h0;
      mr_sync_ff <= 2'h3;
    end else begin
      kick_sync_ff <= {kick_sync_ff[1:0], general_pin_four};
      en_sync_ff <= {en_sync_ff[0], monitor_enable_in};
      mr_sync_ff <= {mr_sync_ff[0], manual_restart_input_b};
    end
  end

  // Either edge of the pin, only when the pin carries the kick function
  assign kick_edge = pin_four_is_kick && (kick_sync_ff[2] != kick_sync_ff[1]);
  assign kick = kick_edge || soft_kick_ff;

  assign independent = mode_ff[wdt_pkg::MODE_INDEP_BIT];
  assign ctrl_wr = reg_wr && (reg_addr == wdt_pkg::CTRL_OFS);
  assign status_wr = reg_wr && (reg_addr == wdt_pkg::STATUS_OFS);

  // Register writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= wdt_pkg::MODE_RST;
      timing_ff <= wdt_pkg::TIMING_RST;
    end else if (reg_wr) begin
      if (reg_addr == wdt_pkg::MODE_OFS) begin
        mode_ff <= reg_wdata;
      end
      if (reg_addr == wdt_pkg::TIMING_OFS) begin
        timing_ff <= reg_wdata;
      end
    end
  end

  // Self-clearing kick bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      soft_kick_ff <= 1'b0;
    end else begin
      soft_kick_ff <= ctrl_wr && reg_wdata[wdt_pkg::CTRL_KICK_BIT];
    end
  end

  // Restart flag, write one clears, setting wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= 1'b0;
    end else if (rst_start) begin
      flag_ff <= 1'b1;
    end else if (status_wr && reg_wdata[wdt_pkg::STATUS_FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  // Registered read data
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        wdt_pkg::MODE_OFS: rdata_ff <= mode_ff;
        wdt_pkg::TIMING_OFS: rdata_ff <= timing_ff;
        wdt_pkg::STATUS_OFS: rdata_ff <= {7'h00, flag_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Free-running microsecond and millisecond prescaler
  assign us_tick = (us_div_ff == 5'(wdt_pkg::US_CYC - 1));
  assign ms_tick = us_tick && (ms_div_ff == 10'(wdt_pkg::US_PER_MS - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      us_div_ff <= 5'h00;
      ms_div_ff <= 10'h000;
    end else begin
      us_div_ff <= us_tick ? 5'h00 : us_div_ff + 5'h01;
      if (ms_tick) begin
        ms_div_ff <= 10'h000;
      end else if (us_tick) begin
        ms_div_ff <= ms_div_ff + 10'h001;
      end
    end
  end

  // Conditions that keep the watchdog cleared
  always_comb begin
    if (independent) begin
      held = !boot_done || wd_rst_ff || soft_reboot;
    end else begin
      held = !en_sync_ff[1] || other_reset_active || wd_rst_ff
             || !mr_sync_ff[1] || soft_reboot;
    end
  end

  // Supervision sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    expire = 1'b0;
    if (held || (timing_ff.timeout == 4'h0)) begin
      nxt_state = wdt_pkg::ST_HOLD;
      nxt_cnt = 19'h00000;
    end else begin
      case (state_ff)
        wdt_pkg::ST_HOLD: begin
          nxt_cnt = 19'h00000;
          if (timing_ff.grace != 3'h0) begin
            nxt_state = wdt_pkg::ST_GRACE;
          end else begin
            nxt_state = wdt_pkg::ST_RUN;
          end
        end
        wdt_pkg::ST_GRACE: begin
          if (kick) begin
            nxt_state = wdt_pkg::ST_RUN;
            nxt_cnt = 19'h00000;
          end else if (ms_tick) begin
            if (cnt_ff >= wdt_pkg::grace_ms(timing_ff.grace)) begin
              expire = 1'b1;
              nxt_state = wdt_pkg::ST_EXPIRED;
            end else begin
              nxt_cnt = cnt_ff + 19'h00001;
            end
          end
        end
        wdt_pkg::ST_RUN: begin
          if (kick) begin
            nxt_cnt = 19'h00000;
          end else if (ms_tick) begin
            if (cnt_ff >= wdt_pkg::timeout_ms(timing_ff.timeout)) begin
              expire = 1'b1;
              nxt_state = wdt_pkg::ST_EXPIRED;
            end else begin
              nxt_cnt = cnt_ff + 19'h00001;
            end
          end
        end
        wdt_pkg::ST_EXPIRED: begin
          if (kick) begin
            nxt_state = wdt_pkg::ST_RUN;
            nxt_cnt = 19'h00000;
          end
        end
        default: begin
          nxt_state = wdt_pkg::ST_HOLD;
          nxt_cnt = 19'h00000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= wdt_pkg::ST_HOLD;
      cnt_ff <= 19'h00000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign rst_start = expire && timing_ff.rst_out_en;

  // Watchdog reset request for the restart pulse period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wd_rst_ff <= 1'b0;
      rst_us_ff <= 20'h00000;
    end else if (rst_start) begin
      wd_rst_ff <= 1'b1;
      rst_us_ff <= wdt_pkg::restart_pulse_us(restart_pulse_code);
    end else if (wd_rst_ff && us_tick) begin
      // Release only after a full period, never early
      if (rst_us_ff == 20'h00000) begin
        wd_rst_ff <= 1'b0;
      end else begin
        rst_us_ff <= rst_us_ff - 20'h00001;
      end
    end
  end

  // Short expiry pulse that starts with a watchdog reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_ff <= 5'h00;
    end else if (rst_start) begin
      pulse_ff <= 5'(wdt_pkg::EXPIRY_PULSE_CYC);
    end else if (pulse_ff != 5'h00) begin
      pulse_ff <= pulse_ff - 5'h01;
    end
  end

  // Expiry output, low from expiry until a kick or hold; only a short pulse when the expiry starts a watchdog reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdo_b_ff <= 1'b1;
    end else if (expire) begin
      wdo_b_ff <= 1'b0;
    end else if (pulse_ff != 5'h00) begin
      wdo_b_ff <= (pulse_ff == 5'h01) ? 1'b1 : wdo_b_ff;
    end else if (kick || held) begin
      wdo_b_ff <= 1'b1;
    end
  end

  assign reg_rdata = rdata_ff;
  assign watchdog_expiry_output_b = wdo_b_ff;
  assign watchdog_reset_out = wd_rst_ff;
  assign watchdog_caused_restart_flag = flag_ff;

endmodule

// ---- design/wdt_pkg.sv ----
// Constants, types and period tables for the supervisor watchdog
package wdt_pkg;
  localparam logic [7:0] MODE_OFS = 8'h73;
  localparam logic [7:0] CTRL_OFS = 8'h75;
  localparam logic [7:0] TIMING_OFS = 8'h76;
  localparam logic [7:0] STATUS_OFS = 8'h77;
  localparam int MODE_INDEP_BIT = 4;
  localparam int CTRL_KICK_BIT = 5;
  localparam int STATUS_FLAG_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int EXPIRY_PULSE_NS = 1000;
  localparam int EXPIRY_PULSE_CYC = (EXPIRY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic rst_out_en;
    logic [2:0] grace;
    logic [3:0] timeout;
  } timing_cfg_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_GRACE = 4'h2,
    ST_RUN = 4'h4,
    ST_EXPIRED = 4'h8
  } wdt_state_t;

  function automatic logic [18:0] grace_ms(input logic [2:0] code);
    case (code)
      3'h1: grace_ms = 19'd30000;
      3'h2: grace_ms = 19'd40000;
      3'h3: grace_ms = 19'd80000;
      3'h4: grace_ms = 19'd120000;
      3'h5: grace_ms = 19'd160000;
      3'h6: grace_ms = 19'd220000;
      3'h7: grace_ms = 19'd300000;
      default: grace_ms = 19'd0;
    endcase
  endfunction

  function automatic logic [18:0] timeout_ms(input logic [3:0] code);
    case (code)
      4'h1: timeout_ms = 19'd1;
      4'h2: timeout_ms = 19'd2;
      4'h3: timeout_ms = 19'd4;
      4'h4: timeout_ms = 19'd8;
      4'h5: timeout_ms = 19'd14;
      4'h6: timeout_ms = 19'd27;
      4'h7: timeout_ms = 19'd50;
      4'h8: timeout_ms = 19'd100;
      4'h9: timeout_ms = 19'd200;
      4'hA: timeout_ms = 19'd400;
      4'hB: timeout_ms = 19'd750;
      4'hC: timeout_ms = 19'd1400;
      4'hD: timeout_ms = 19'd2700;
      4'hE: timeout_ms = 19'd5000;
      4'hF: timeout_ms = 19'd10000;
      default: timeout_ms = 19'd0;
    endcase
  endfunction

  function automatic logic [19:0] restart_pulse_us(input logic [3:0] code);
    case (code)
      4'h0: restart_pulse_us = 20'd25;
      4'h1: restart_pulse_us = 20'd1500;
      4'h2: restart_pulse_us = 20'd2500;
      4'h3: restart_pulse_us = 20'd4000;
      4'h4: restart_pulse_us = 20'd6000;
      4'h5: restart_pulse_us = 20'd10000;
      4'h6: restart_pulse_us = 20'd15000;
      4'h7: restart_pulse_us = 20'd25000;
      4'h8: restart_pulse_us = 20'd40000;
      4'h9: restart_pulse_us = 20'd60000;
      4'hA: restart_pulse_us = 20'd100000;
      4'hB: restart_pulse_us = 20'd150000;
      4'hC: restart_pulse_us = 20'd250000;
      4'hD: restart_pulse_us = 20'd400000;
      4'hE: restart_pulse_us = 20'd600000;
      default: restart_pulse_us = 20'd1000000;
    endcase
  endfunction
endpackage

// ---- test/wdt_kick_host.sv ----
// Host processor model that toggles the kick pin on request
`timescale 1ns/10ps
module wdt_kick_host (
  input wire logic mclk, // Device clock
  input wire logic rst_b, // Reset, low active
  input wire logic go, // Request one toggle
  input wire logic [15:0] gap, // Cycles before the toggle
  output logic kick_pin // Kick pin level
);
  logic [15:0] wait_ff;
  logic busy_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 16'h0000;
      busy_ff <= 1'b0;
      kick_pin <= 1'b0;
    end else if (go) begin
      wait_ff <= gap;
      busy_ff <= 1'b1;
    end else if (busy_ff && wait_ff == 16'h0000) begin
      kick_pin <= ~kick_pin;
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 16'h0001;
    end
  end
endmodule

// ---- test/supervisor_watchdog_timer_props.sv ----
// Port-level checker for the supervisor watchdog
`timescale 1ns/10ps
module wdt_props (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Reset, low active
  input wire logic monitor_enable_in, // Enable pin
  input wire logic other_reset_active, // Other reset cause
  input wire logic [3:0] restart_pulse_code, // Pulse code
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic watchdog_expiry_output_b, // Expiry, low active
  input wire logic watchdog_reset_out, // Reset request
  input wire logic watchdog_caused_restart_flag // Restart flag
);
  logic indep_ff;
  logic ren_ff;
  logic [3:0] tmo_ff;
  logic [9:0] rcnt_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Shadows of the mode and timing registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      indep_ff <= 1'b0;
      ren_ff <= 1'b0;
      tmo_ff <= 4'h0;
    end else if (reg_wr && reg_addr == 8'h73) begin
      indep_ff <= reg_wdata[4];
    end else if (reg_wr && reg_addr == 8'h76) begin
      ren_ff <= reg_wdata[7];
      tmo_ff <= reg_wdata[3:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_ff <= 10'h000;
    end else begin
      rcnt_ff <= watchdog_reset_out ? rcnt_ff + 10'h001 : 10'h000;
    end
  end
  a_flag_on_reset: assert property ($rose(watchdog_reset_out) |-> watchdog_caused_restart_flag)
    else $error("restart flag not set with reset");
  a_expiry_short_pulse: assert property ($rose(watchdog_reset_out) |-> !watchdog_expiry_output_b [*8] ##[8:16] watchdog_expiry_output_b)
    else $error("expiry pulse wrong");
  a_no_reset_disabled: assert property (!ren_ff |=> !$rose(watchdog_reset_out))
    else $error("reset raised while disabled");
  a_reset_pulse_len: assert property ($fell(watchdog_reset_out) && restart_pulse_code == 4'h0 |-> rcnt_ff >= 10'd500 && rcnt_ff <= 10'd522)
    else $error("reset pulse length wrong");
  a_soft_kick_release: assert property (indep_ff && reg_wr && reg_addr == 8'h75 && reg_wdata[5] && !watchdog_expiry_output_b && !watchdog_reset_out |-> ##[1:4] watchdog_expiry_output_b)
    else $error("soft kick did not release expiry");
  a_dep_enable_hold: assert property (!indep_ff && !monitor_enable_in [*4] |=> watchdog_expiry_output_b || watchdog_reset_out)
    else $error("expiry while enable low");
  a_dep_reset_hold: assert property (!indep_ff && other_reset_active [*2] |=> watchdog_expiry_output_b || watchdog_reset_out)
    else $error("expiry while reset held");
  a_disabled_quiet: assert property (tmo_ff == 4'h0 |=> !$fell(watchdog_expiry_output_b))
    else $error("expiry while disabled");
endmodule

// ---- test/supervisor_watchdog_timer_bench.sv ----
// Self-checking bench for the supervisor watchdog
`timescale 1ns/10ps
module supervisor_watchdog_timer_bench;
  logic mclk, rst_b, general_pin_four, pin_four_is_kick, monitor_enable_in, manual_restart_input_b;
  logic boot_done, soft_reboot, other_reset_active, reg_wr, go;
  logic watchdog_expiry_output_b, watchdog_reset_out, watchdog_caused_restart_flag;
  logic [3:0] restart_pulse_code;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] gap;
  int error_cnt = 0;
  int samples_checked = 0;
  supervisor_watchdog_timer uut (.mclk, .rst_b, .general_pin_four, .pin_four_is_kick, .monitor_enable_in,
    .manual_restart_input_b, .boot_done, .soft_reboot, .other_reset_active, .restart_pulse_code, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rdata, .watchdog_expiry_output_b, .watchdog_reset_out, .watchdog_caused_restart_flag);
  wdt_kick_host host (.mclk, .rst_b, .go, .gap, .kick_pin(general_pin_four));
  always #25 mclk = ~mclk;
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic wait_sig(input bit sel, input logic lvl, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      #1;
      if ((sel ? watchdog_reset_out : watchdog_expiry_output_b) === lvl) return;
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic t_regs();
    rd_chk(8'h73, 8'h00);
    rd_chk(8'h76, 8'h00);
    rd_chk(8'h77, 8'h00);
    wr_reg(8'h76, 8'hF5);
    rd_chk(8'h76, 8'hF5);
    wr_reg(8'h76, 8'h00);
    wr_reg(8'h73, 8'h10);
    rd_chk(8'h73, 8'h10);
    wr_reg(8'h80, 8'hFF);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h75, 8'h00);
  endtask
  // Independent mode, expiry without reset output
  task automatic t_indep();
    int n;
    wr_reg(8'h76, 8'h01);
    @(posedge mclk);
    gap <= 16'h0020;
    go <= 1'b1;
    monitor_enable_in <= 1'b0;
    @(posedge mclk);
    go <= 1'b0;
    repeat (40) @(posedge mclk);
    wait_sig(1'b0, 1'b0, 42000, n);
    chk("expiry_delay", n >= 19990 && n <= 40010, 1);
    chk("reset_out", watchdog_reset_out, 0);
    repeat (100) @(posedge mclk);
    #1;
    chk("expiry_held", watchdog_expiry_output_b, 0);
    wr_reg(8'h75, 8'h20);
    repeat (3) @(posedge mclk);
    #1;
    chk("expiry_kicked", watchdog_expiry_output_b, 1);
    @(posedge mclk);
    monitor_enable_in <= 1'b1;
  endtask
  // Dependent mode, expiry drives the reset output
  task automatic t_dep();
    int n;
    int p;
    wr_reg(8'h73, 8'h00);
    wr_reg(8'h76, 8'h81);
    @(posedge mclk);
    other_reset_active <= 1'b1;
    repeat (3) @(posedge mclk);
    other_reset_active <= 1'b0;
    monitor_enable_in <= 1'b0;
    repeat (6) @(posedge mclk);
    monitor_enable_in <= 1'b1;
    wait_sig(1'b0, 1'b0, 42000, n);
    chk("reset_out", watchdog_reset_out, 1);
    chk("restart_flag", watchdog_caused_restart_flag, 1);
    wait_sig(1'b0, 1'b1, 30, p);
    chk("pulse_len", p >= 15 && p <= 24, 1);
    wait_sig(1'b1, 1'b0, 600, n);
    chk("reset_len", p + n + 2 >= 500 && p + n + 2 <= 522, 1);
    rd_chk(8'h77, 8'h01);
    wr_reg(8'h77, 8'h01);
    rd_chk(8'h77, 8'h00);
    wr_reg(8'h76, 8'h00);
  endtask
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    pin_four_is_kick = 1'b1;
    monitor_enable_in = 1'b1;
    manual_restart_input_b = 1'b1;
    boot_done = 1'b1;
    soft_reboot = 1'b0;
    other_reset_active = 1'b0;
    restart_pulse_code = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    go = 1'b0;
    gap = 16'h0000;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_indep();
    t_dep();
    give_verdict();
  end
endmodule
bind supervisor_watchdog_timer wdt_props chk_i (.mclk, .rst_b, .monitor_enable_in, .other_reset_active,
  .restart_pulse_code, .reg_addr, .reg_wdata, .reg_wr, .watchdog_expiry_output_b, .watchdog_reset_out,
  .watchdog_caused_restart_flag);
